// *** nvsrc_ctrl.sv ***
// Purpose: Store/recall sequencing between serial RAM and shadow array
// Assumes: Commands arrive decoded as one-cycle pulses from the serial
//          front end; request pins are asynchronous, active low
// Notes:   Contract
`timescale 1ns/1ps

module nvsrc_ctrl
    import nvsrc_pkg::*;
#(
    parameter int unsigned STORE_CYC = STORE_DURATION_CYC
) (
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clk_en_i,
    input  wire logic       chip_sel_i,
    input  wire logic       store_req_n_i,
    input  wire logic       recall_req_n_i,
    input  wire logic       no_instruction_active_i,
    input  wire logic       cmd_valid_i,
    input  wire logic [2:0] cmd_op_i,
    output logic            store_busy_o,
    output logic            recall_busy_o,
    output logic            write_latch_o,
    output logic            recall_done_o,
    output logic            xfer_start_o
);
    import nvsrc_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] st_sync_reg, st_sync_next;
    logic [1:0] rc_sync_reg, rc_sync_next;
    logic [1:0] cs_sync_reg, cs_sync_next;

    // Two flops per pin; only bit 1 is read by logic
    always_comb begin
        st_sync_next = {st_sync_reg[0], store_req_n_i};
        rc_sync_next = {rc_sync_reg[0], recall_req_n_i};
        cs_sync_next = {cs_sync_reg[0], chip_sel_i};
    end

    // Pins idle high; chip select idles deselected
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_sync_reg <= 2'h3;
            rc_sync_reg <= 2'h3;
            cs_sync_reg <= 2'h0;
        end else if (clk_en_i) begin
            st_sync_reg <= st_sync_next;
            rc_sync_reg <= rc_sync_next;
            cs_sync_reg <= cs_sync_next;
        end
    end

    logic st_low, rc_low, cs_on;
    assign st_low = ~st_sync_reg[1];
    assign rc_low = ~rc_sync_reg[1];
    assign cs_on  = cs_sync_reg[1];

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    logic armed_reg, armed_next;  // store pin seen high since last store
    logic [CNT_W-1:0] pulse_reg, pulse_next;
    logic hw_ok, sw_store, sw_recall, hw_recall, hw_store, latches_ok;

    always_comb begin
        hw_ok      = no_instruction_active_i;
        latches_ok = write_latch_o & recall_done_o;
        sw_store   = cmd_valid_i && cmd_op_i == OP_STORE
                     && !st_low && !rc_low;
        sw_recall  = cmd_valid_i && cmd_op_i == OP_RECALL
                     && !st_low && !rc_low;
        hw_recall  = hw_ok && rc_low;
        // Short glitches are filtered by the minimum pulse count
        hw_store   = hw_ok && st_low && !rc_low && cs_on
                     && armed_reg
                     && pulse_reg >= CNT_W'(STORE_PULSE_MIN_CYC - 1);
    end

    // ------------------------------------------------------------
    // Sequencer and latches
    // ------------------------------------------------------------
    nvsrc_state_t     state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic             wl_next, rd_next, start_next;

    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        wl_next    = write_latch_o;
        rd_next    = recall_done_o;
        start_next = 1'b0;
        armed_next = armed_reg | ~st_low;
        pulse_next = st_low ? pulse_reg + CNT_W'(1) : '0;
        case (state_reg)
            NVSRC_IDLE: begin
                if (hw_recall || sw_recall) begin
                    // Recall has priority; latch state is irrelevant
                    state_next = NVSRC_RECALL;
                    cnt_next   = CNT_W'(RECALL_CYC - 1);
                    rd_next    = 1'b1;
                    start_next = 1'b1;
                end else if ((hw_store || sw_store) && latches_ok) begin
                    state_next = NVSRC_STORE;
                    cnt_next   = CNT_W'(STORE_CYC - 1);
                    armed_next = 1'b0;
                    start_next = 1'b1;
                end else if (cmd_valid_i) begin
                    if (cmd_op_i == OP_WRITE_LATCH_SET)
                        wl_next = 1'b1;
                    else if (cmd_op_i == OP_WRITE_LATCH_CLR)
                        wl_next = 1'b0;
                end
            end
            NVSRC_STORE: begin
                // Every request and command is dropped here
                armed_next = 1'b0;
                if (cnt_reg == '0) begin
                    state_next = NVSRC_IDLE;
                    wl_next    = 1'b0;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            NVSRC_RECALL: begin
                if (cnt_reg == '0)
                    state_next = NVSRC_IDLE;
                else
                    cnt_next = cnt_reg - CNT_W'(1);
            end
            default: state_next = NVSRC_IDLE;
        endcase
    end

    // Latches clear on reset, never set by the power-up recall
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg     <= NVSRC_IDLE;
            cnt_reg       <= '0;
            pulse_reg     <= '0;
            armed_reg     <= 1'b0;
            write_latch_o <= LATCH_RESET_VAL;
            recall_done_o <= LATCH_RESET_VAL;
            xfer_start_o  <= 1'b0;
        end else if (clk_en_i) begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            pulse_reg     <= pulse_next;
            armed_reg     <= armed_next;
            write_latch_o <= wl_next;
            recall_done_o <= rd_next;
            xfer_start_o  <= start_next;
        end
    end

    // Busy flags registered alongside the state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            store_busy_o  <= 1'b0;
            recall_busy_o <= 1'b0;
        end else if (clk_en_i) begin
            store_busy_o  <= state_next == NVSRC_STORE;
            recall_busy_o <= state_next == NVSRC_RECALL;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_store_ends;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (store_busy_o && cnt_reg == '0 && clk_en_i) |=> !store_busy_o;
    endproperty
    a_store_ends: assert property (p_store_ends)
        else $error("store did not end at count zero");

    property p_no_store_unsel;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        ($rose(store_busy_o) && !$past(sw_store))
            |-> $past(cs_on && !rc_low && st_low);
    endproperty
    a_no_store_unsel: assert property (p_no_store_unsel)
        else $error("hardware store started while blocked");

    property p_hw_recall;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg == NVSRC_IDLE && hw_recall && clk_en_i)
            |=> recall_busy_o && recall_done_o;
    endproperty
    a_hw_recall: assert property (p_hw_recall)
        else $error("hardware recall not taken");

    property p_sw_recall;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg == NVSRC_IDLE && sw_recall && clk_en_i)
            |=> recall_busy_o;
    endproperty
    a_sw_recall: assert property (p_sw_recall)
        else $error("software recall not taken");

    property p_store_needs_latches;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(store_busy_o) |-> $past(write_latch_o && recall_done_o);
    endproperty
    a_store_needs_latches: assert property (p_store_needs_latches)
        else $error("store started without both latches");

    property p_wl_cleared;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(store_busy_o) |-> !write_latch_o;
    endproperty
    a_wl_cleared: assert property (p_wl_cleared)
        else $error("write latch still set after store");

    property p_store_blocks;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        store_busy_o |=> !recall_busy_o && !$rose(write_latch_o);
    endproperty
    a_store_blocks: assert property (p_store_blocks)
        else $error("activity during store");

    property p_both_low;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(store_busy_o) |-> $past(!rc_low);
    endproperty
    a_both_low: assert property (p_both_low)
        else $error("store with recall pin low");

    property p_wl_set;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg == NVSRC_IDLE && clk_en_i && cmd_valid_i
         && cmd_op_i == OP_WRITE_LATCH_SET && !hw_recall)
            |=> write_latch_o;
    endproperty
    a_wl_set: assert property (p_wl_set)
        else $error("write latch not set by command");

    c_store:  cover property (@(posedge core_clk_i) $fell(store_busy_o));
    c_recall: cover property (@(posedge core_clk_i) $rose(recall_busy_o));
    c_wl:     cover property (@(posedge core_clk_i) $rose(write_latch_o));

endmodule // nvsrc_ctrl

// *** nvsrc_pkg.sv ***
// Purpose: Shared constants for the store/recall controller
// Assumes: Core clock of 20 MHz
// Notes:   Times are kept in their own unit, cycle counts derived here
package nvsrc_pkg;

    localparam int unsigned CLK_PERIOD_NS       = 50;
    // Store duration upper bound, in microseconds
    localparam int unsigned STORE_DURATION_US   = 5000;
    // Longest time rounds down to whole cycles
    localparam int unsigned STORE_DURATION_CYC  =
        (STORE_DURATION_US * 1000) / CLK_PERIOD_NS;
    // Shortest store request pulse, in nanoseconds
    localparam int unsigned STORE_PULSE_MIN_NS  = 200;
    // Least time rounds up
    localparam int unsigned STORE_PULSE_MIN_CYC =
        (STORE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Recall cycle time, in nanoseconds
    localparam int unsigned RECALL_TIME_NS      = 2000;
    localparam int unsigned RECALL_CYC          =
        (RECALL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W               = 17;

    // Decoded serial command codes, low three instruction bits
    localparam logic [2:0]  OP_WRITE_LATCH_CLR  = 3'h0;
    localparam logic [2:0]  OP_STORE            = 3'h1;
    localparam logic [2:0]  OP_WRITE_LATCH_SET  = 3'h4;
    localparam logic [2:0]  OP_RECALL           = 3'h5;

    localparam logic        LATCH_RESET_VAL     = 1'b0;

    typedef enum logic [2:0] {
        NVSRC_IDLE   = 3'b001,
        NVSRC_STORE  = 3'b010,
        NVSRC_RECALL = 3'b100
    } nvsrc_state_t;

endpackage : nvsrc_pkg

// *** nvsrc_host_model.sv ***
// Purpose: Host model driving command pulses and request pins
// Assumes: Pins idle high through pull-ups; drives on falling edges
// Notes:   Behavioural; keeps the host-side timing rules
`timescale 1ns/1ps

module nvsrc_host_model (
    input  wire logic       core_clk_i,
    output logic            chip_sel_o,
    output logic            store_req_n_o,
    output logic            recall_req_n_o,
    output logic            no_instruction_active_o,
    output logic            cmd_valid_o,
    output logic [2:0]      cmd_op_o
);
    import nvsrc_pkg::*;

    // Idle: selected, pins released high, no instruction running
    initial begin
        chip_sel_o              = 1'b1;
        store_req_n_o           = 1'b1;
        recall_req_n_o          = 1'b1;
        no_instruction_active_o = 1'b1;
        cmd_valid_o             = 1'b0;
        cmd_op_o                = 3'h0;
    end

    // Scaled power-up wait before any read, write or store
    task automatic power_up_wait();
        repeat (8) @(negedge core_clk_i);
    endtask

    // One-cycle decoded command pulse
    task automatic send_cmd(input logic [2:0] op);
        @(negedge core_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_op_o    <= op;
        @(negedge core_clk_i);
        cmd_valid_o <= 1'b0;
    endtask

    // Pins change together; callers hold store low >= 4 cycles
    task automatic set_pins(input logic st_n, input logic rc_n,
                            input logic cs, input logic idle);
        @(negedge core_clk_i);
        store_req_n_o           <= st_n;
        recall_req_n_o          <= rc_n;
        chip_sel_o              <= cs;
        no_instruction_active_o <= idle;
    endtask

    // Clear latch only once the store has ended
    task automatic clear_after_store(input logic busy);
        if (busy !== 1'b1) begin
            send_cmd(OP_WRITE_LATCH_CLR);
        end
    endtask
endmodule // nvsrc_host_model

// *** nvsrc_ctrl_tb.sv ***
// Purpose: Self-checking bench for the store/recall controller
// Assumes: STORE_CYC shortened to 20 cycles for simulation
// Notes:   Host model drives request pins and commands; bench drives reset and enable
`timescale 1ns/1ps

module nvsrc_ctrl_tb;
    import nvsrc_pkg::*;
    localparam int unsigned SIM_STORE_CYC = 20;
    logic       core_clk_i, rst_n_i, clk_en_i, cs, st_n, rc_n, idle, cv;
    logic [2:0] op;
    logic       s_busy, r_busy, wl, rd, xs;
    int         bad_count, compares;

    nvsrc_ctrl #(.STORE_CYC(SIM_STORE_CYC)) u_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .chip_sel_i(cs), .store_req_n_i(st_n), .recall_req_n_i(rc_n),
        .no_instruction_active_i(idle), .cmd_valid_i(cv), .cmd_op_i(op),
        .store_busy_o(s_busy), .recall_busy_o(r_busy),
        .write_latch_o(wl), .recall_done_o(rd), .xfer_start_o(xs));

    nvsrc_host_model u_host (
        .core_clk_i(core_clk_i), .chip_sel_o(cs), .store_req_n_o(st_n),
        .recall_req_n_o(rc_n), .no_instruction_active_o(idle),
        .cmd_valid_o(cv), .cmd_op_o(op));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    function automatic logic pick(input int w);
        case (w)
            0: pick = s_busy;
            1: pick = r_busy;
            2: pick = wl;
            3: pick = rd;
            default: pick = xs;
        endcase
    endfunction

    task automatic final_report();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Waits up to lim cycles for output w to reach val; seen must be exp
    task automatic expect_sig(input int w, input logic val, input int lim,
                              input logic exp);
        logic seen;
        // Sample once at hand-over so a one-cycle pulse is not missed
        seen = (pick(w) === val);
        for (int i = 0; i < lim && seen !== 1'b1; i++) begin
            @(negedge core_clk_i);
            if (pick(w) === val) seen = 1'b1;
        end
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t output %0d mismatch", $time, w);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_sw_guard();
        expect_sig(3, 1'b0, 1, 1'b1);
        expect_sig(2, 1'b0, 1, 1'b1);
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        expect_sig(2, 1'b1, 3, 1'b1);
        u_host.send_cmd(OP_STORE);
        expect_sig(0, 1'b1, 6, 1'b0);
        u_host.send_cmd(OP_WRITE_LATCH_CLR);
        expect_sig(2, 1'b0, 3, 1'b1);
        $display("done sw_guard");
    endtask

    task automatic t_sw_recall();
        u_host.send_cmd(OP_RECALL);
        expect_sig(4, 1'b1, 3, 1'b1);
        expect_sig(3, 1'b1, 1, 1'b1);
        expect_sig(1, 1'b0, 45, 1'b1);
        $display("done sw_recall");
    endtask

    task automatic t_sw_store();
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        u_host.send_cmd(OP_STORE);
        expect_sig(0, 1'b1, 3, 1'b1);
        u_host.send_cmd(OP_RECALL);
        expect_sig(1, 1'b1, 4, 1'b0);
        expect_sig(0, 1'b0, SIM_STORE_CYC + 2, 1'b1);
        expect_sig(2, 1'b0, 1, 1'b1);
        u_host.clear_after_store(s_busy);
        $display("done sw_store");
    endtask

    task automatic t_hw_recall();
        u_host.set_pins(1'b1, 1'b0, 1'b1, 1'b0);
        expect_sig(1, 1'b1, 8, 1'b0);
        u_host.set_pins(1'b1, 1'b0, 1'b1, 1'b1);
        expect_sig(1, 1'b1, 6, 1'b1);
        u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        expect_sig(1, 1'b0, 45, 1'b1);
        $display("done hw_recall");
    endtask

    task automatic t_hw_store();
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        u_host.set_pins(1'b0, 1'b1, 1'b0, 1'b1);
        expect_sig(0, 1'b1, 12, 1'b0);
        u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        repeat (4) @(negedge core_clk_i);
        u_host.set_pins(1'b0, 1'b1, 1'b1, 1'b1);
        expect_sig(0, 1'b1, 10, 1'b1);
        expect_sig(0, 1'b0, SIM_STORE_CYC + 2, 1'b1);
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        expect_sig(2, 1'b1, 3, 1'b1);
        expect_sig(0, 1'b1, 12, 1'b0);
        u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        $display("done hw_store");
    endtask

    task automatic t_both_low();
        u_host.set_pins(1'b0, 1'b0, 1'b1, 1'b1);
        expect_sig(1, 1'b1, 8, 1'b1);
        expect_sig(0, 1'b1, 45, 1'b0);
        u_host.set_pins(1'b1, 1'b1, 1'b1, 1'b1);
        expect_sig(1, 1'b0, 90, 1'b1);
        $display("done both_low");
    endtask

    // Enable low freezes the latch; a mid-run reset clears both latches
    task automatic t_freeze_reset();
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        expect_sig(2, 1'b1, 3, 1'b1);
        @(negedge core_clk_i);
        clk_en_i = 1'b0;
        u_host.send_cmd(OP_WRITE_LATCH_CLR);
        expect_sig(2, 1'b0, 4, 1'b0);
        clk_en_i = 1'b1;
        @(negedge core_clk_i);
        rst_n_i = 1'b0;
        repeat (20) @(negedge core_clk_i);
        expect_sig(2, 1'b0, 1, 1'b1);
        expect_sig(3, 1'b0, 1, 1'b1);
        rst_n_i = 1'b1;
        u_host.power_up_wait();
        u_host.send_cmd(OP_WRITE_LATCH_SET);
        u_host.send_cmd(OP_STORE);
        expect_sig(0, 1'b1, 6, 1'b0);
        $display("done freeze_reset");
    endtask

    // Clock, 50 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    // Watchdog: tests need well under 1000 cycles
    initial begin
        repeat (5000) @(posedge core_clk_i);
        bad_count++;
        final_report();
    end

    // Main sequence
    initial begin
        bad_count = 0;
        compares  = 0;
        clk_en_i  = 1'b1;
        rst_n_i   = 1'b0;
        repeat (20) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        u_host.power_up_wait();
        t_sw_guard();
        t_sw_recall();
        t_sw_store();
        t_hw_recall();
        t_hw_store();
        t_both_low();
        t_freeze_reset();
        final_report();
    end
endmodule // nvsrc_ctrl_tb
